// ===== rtl/sdi_pkg.sv
// shared constants, register map and carrier types of the servo discrete-input block
package sdi_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned RESET_HOLD_MS   = 50;
  // a least time: converted to whole cycles with no rounding up
  localparam int unsigned RESET_HOLD_CYC  = (CLK_HZ / 1000 * RESET_HOLD_MS + 0) ;
  localparam int unsigned HOLD_W          = 22;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_INT_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_INT_CLEAR   = 8'h0c;
  localparam logic [7:0] ADDR_INT_ENABLE  = 8'h10;

  // control register fields
  localparam int unsigned CTRL_SLOW_STOP  = 0;
  localparam int unsigned CTRL_KEEP_BASE  = 1;
  localparam int unsigned CTRL_IO_LSB     = 2;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam int unsigned CTRL_W          = 4;

  // function of the bidirectional pin
  localparam logic [1:0] IO_UNUSED        = 2'h0;
  localparam logic [1:0] IO_FORCED_STOP   = 2'h1;
  localparam logic [1:0] IO_AUTO_MANUAL   = 2'h2;
  localparam logic [1:0] IO_TROUBLE_OUT   = 2'h3;

  // status register fields
  localparam int unsigned ST_BASE         = 4;
  localparam int unsigned ST_DBRAKE       = 5;
  localparam int unsigned ST_CCW          = 6;
  localparam int unsigned ST_CW           = 7;
  localparam int unsigned ST_FSTOP_IN     = 8;
  localparam int unsigned ST_AUTO_IN      = 9;
  localparam int unsigned ST_ALARM_LSB    = 16;

  // interrupt bits
  localparam int unsigned IRQ_W           = 5;
  localparam int unsigned IRQ_FSTOP       = 0;
  localparam int unsigned IRQ_ALARM       = 1;
  localparam int unsigned IRQ_ALARM_CLR   = 2;
  localparam int unsigned IRQ_STROKE      = 3;
  localparam int unsigned IRQ_RESUME      = 4;

  // alarms
  localparam int unsigned ALARM_W         = 8;
  // alarm types that a reset pulse may clear; the upper two stay latched
  localparam logic [7:0]  ALARM_RESETTABLE = 8'h3f;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    SDI_OFF   = 4'h1,
    SDI_ON    = 4'h2,
    SDI_FSTOP = 4'h4,
    SDI_ALARM = 4'h8
  } sdi_state_t;

  typedef struct packed {
    logic servo_on_input;
    logic alarm_reset_input;
    logic fwd_stroke_end_input;
    logic rev_stroke_end_input;
    logic program_resume_input_1;
  } sdi_pins_t;

  typedef struct packed {
    logic base_enable;
    logic dyn_brake;
    logic servo_lock;
    logic sudden_stop;
    logic slow_stop;
    logic ccw_permit;
    logic cw_permit;
    logic program_mode;
    logic trouble_output;
  } sdi_drive_t;

endpackage

// ===== rtl/sdi_hold_timer.sv
// pulse once a level has been held without a break for longer than a set time
`timescale 1ns/1ps
module sdi_hold_timer
  import sdi_pkg::*;
#(
  parameter logic [HOLD_W-1:0] HOLD = HOLD_W'(RESET_HOLD_CYC)
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic level,
  output logic      fire
);

  logic [HOLD_W-1:0] cnt;
  logic [HOLD_W-1:0] next_cnt;
  logic              next_fire;

  // any gap restarts the count; saturating keeps one pulse per press
  always_comb begin
    next_fire = level && (cnt == HOLD);
    if (!level) begin
      next_cnt = '0;
    end else if (cnt == HOLD + HOLD_W'(1)) begin
      next_cnt = cnt;
    end else begin
      next_cnt = cnt + HOLD_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= '0;
      fire <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      fire <= next_fire;
    end
  end

endmodule

// ===== rtl/sdi_core.sv
// servo amplifier discrete control inputs with an AHB-Lite register slave
//
// Contract
// [RULE1] forced-stop off: stop, servo off, dynamic brake
// [RULE2] forced-stop on again leaves forced-stop state
// [RULE3] unassigned forced-stop and mode inputs read on
// [RULE4] servo-on enables base circuit, ready to run
// [RULE5] servo-on off cuts base, motor coasts
// [RULE6] alarm clears after reset held over 50ms
// [RULE7] some alarm types survive a reset pulse
// [RULE8] reset without alarm cuts base unless kept
// [RULE9] controller never resets while the motor runs
// [RULE10] both stroke ends on before starting
// [RULE11] stroke end off: sudden stop, servo lock
// [RULE12] slow-stop setting decelerates instead at stroke end
// [RULE13] spare functions map to bidirectional pin
// [RULE14] stroke ends gate each rotation direction
// [RULE15] resume input one releases first sync wait
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module sdi_core
  import sdi_pkg::*;
#(
  parameter logic [HOLD_W-1:0] RESET_HOLD = HOLD_W'(RESET_HOLD_CYC)
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire sdi_pins_t         pins,
  input  wire logic              io_pin_in,
  output logic                   io_pin_out,
  output logic                   io_pin_oen,
  input  wire logic [ALARM_W-1:0] alarm_raise,
  input  wire logic              motion_ccw_req,
  input  wire logic              motion_cw_req,
  input  wire logic              sync1_wait,
  output logic                   sync1_resume,
  output sdi_drive_t             drive,
  output logic                   irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic rising(input logic now, input logic was);
    return now && !was;
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic             next_wr_pend;
  logic [7:0]       next_wr_addr;
  logic [31:0]      next_hrdata;
  logic             addr_ok;
  logic             take;

  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic [IRQ_W-1:0]  int_status;
  logic [IRQ_W-1:0]  int_enable;
  logic [IRQ_W-1:0]  next_int_status;
  logic [IRQ_W-1:0]  next_int_enable;
  logic [IRQ_W-1:0]  events;
  logic [IRQ_W-1:0]  clr_mask;
  logic [31:0]       status_word;

  // only word-aligned addresses are decoded, whatever the size; anything else reads zero
  assign addr_ok   = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata  = hrdata;
    if (take) begin
      next_wr_pend = hwrite && addr_ok;
      next_wr_addr = haddr[7:0];
      next_hrdata  = 32'h00000000;
      if (!hwrite && addr_ok) begin
        unique case (haddr[7:0])
          ADDR_CTRL:       next_hrdata = {{(32 - CTRL_W){1'b0}}, ctrl};
          ADDR_STATUS:     next_hrdata = status_word;
          ADDR_INT_STATUS: next_hrdata = {{(32 - IRQ_W){1'b0}}, int_status};
          ADDR_INT_ENABLE: next_hrdata = {{(32 - IRQ_W){1'b0}}, int_enable};
          default:         next_hrdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata  <= next_hrdata;
    end
  end

  // ****************************************************************
  // control and interrupt registers
  // ****************************************************************
  always_comb begin
    next_ctrl       = ctrl;
    next_int_enable = int_enable;
    clr_mask        = '0;
    if (wr_pend) begin
      unique case (wr_addr)
        ADDR_CTRL:       next_ctrl       = hwdata[CTRL_W-1:0];
        ADDR_INT_CLEAR:  clr_mask        = hwdata[IRQ_W-1:0];
        ADDR_INT_ENABLE: next_int_enable = hwdata[IRQ_W-1:0];
        default:         next_ctrl       = ctrl;
      endcase
    end
    // a new event in the clearing cycle stays set
    next_int_status = (int_status & ~clr_mask) | events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl       <= CTRL_RESET;
      int_status <= '0;
      int_enable <= '0;
    end else begin
      ctrl       <= next_ctrl;
      int_status <= next_int_status;
      int_enable <= next_int_enable;
    end
  end

  assign irq = |(int_status & int_enable);

  // ****************************************************************
  // pin mapping
  // ****************************************************************
  logic [1:0] io_func;
  logic       fstop_on;
  logic       auto_sel;
  logic       next_io_out;
  logic       next_io_oen;

  assign io_func = ctrl[CTRL_IO_LSB +: 2];
  // with no pin assigned the function is held on internally
  assign fstop_on = (io_func == IO_FORCED_STOP) ? io_pin_in : 1'b1; // [RULE3] [RULE13]
  assign auto_sel = (io_func == IO_AUTO_MANUAL) ? io_pin_in : 1'b1; // [RULE3] [RULE13]

  // ****************************************************************
  // alarms
  // ****************************************************************
  logic [ALARM_W-1:0] alarm;
  logic [ALARM_W-1:0] next_alarm;
  logic               reset_fire;
  logic               alarm_any;

  sdi_hold_timer #(
    .HOLD    (RESET_HOLD)
  ) u_reset_hold (
    .hclk    (hclk),
    .hresetn (hresetn),
    .level   (pins.alarm_reset_input),
    .fire    (reset_fire)
  );

  always_comb begin
    next_alarm = alarm;
    if (reset_fire) begin
      next_alarm = alarm & ~ALARM_RESETTABLE; // [RULE6] [RULE7]
    end
    // a type raised in the reset cycle survives it
    next_alarm = next_alarm | alarm_raise;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm <= '0;
    end else begin
      alarm <= next_alarm;
    end
  end

  assign alarm_any = |alarm;

  // ****************************************************************
  // servo state machine
  // ****************************************************************
  sdi_state_t state;
  sdi_state_t next_state;
  logic       rst_shut;
  logic       resume_was;
  logic       fstop_was;
  logic       stroke_was;
  logic       stroke_hit;
  logic       ccw_ok;
  logic       cw_ok;
  logic       next_resume;
  sdi_drive_t next_drive;

  // a reset press with no alarm cuts the base unless told to keep it
  assign rst_shut = pins.alarm_reset_input && !alarm_any
                    && !ctrl[CTRL_KEEP_BASE]; // [RULE8]

  always_comb begin
    next_state = state;
    if (!fstop_on) begin
      next_state = SDI_FSTOP; // [RULE1]
    end else begin
      unique case (state)
        SDI_FSTOP: next_state = SDI_OFF; // [RULE2]
        SDI_OFF: begin
          if (alarm_any) begin
            next_state = SDI_ALARM;
          end else if (pins.servo_on_input && !rst_shut) begin
            next_state = SDI_ON; // [RULE4]
          end
        end
        SDI_ON: begin
          if (alarm_any) begin
            next_state = SDI_ALARM;
          end else if (!pins.servo_on_input || rst_shut) begin
            next_state = SDI_OFF; // [RULE5] [RULE8]
          end
        end
        SDI_ALARM: begin
          if (!alarm_any) begin
            next_state = SDI_OFF;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // stroke ends and drive outputs
  // ****************************************************************
  // forward end guards ccw travel, reverse end guards cw travel
  assign ccw_ok     = pins.fwd_stroke_end_input; // [RULE14]
  assign cw_ok      = pins.rev_stroke_end_input; // [RULE14]
  // the controller is trusted to start with both ends closed
  assign stroke_hit = (state == SDI_ON)
                      && ((motion_ccw_req && !ccw_ok) || (motion_cw_req && !cw_ok)); // [RULE10]

  always_comb begin
    next_drive                = '0;
    next_drive.base_enable    = (state == SDI_ON);
    next_drive.dyn_brake      = (state == SDI_FSTOP); // [RULE1]
    // the base stays up during a stroke stop so the shaft is held
    next_drive.servo_lock     = (state == SDI_ON); // [RULE11]
    next_drive.sudden_stop    = stroke_hit && !ctrl[CTRL_SLOW_STOP]; // [RULE11]
    next_drive.slow_stop      = stroke_hit && ctrl[CTRL_SLOW_STOP]; // [RULE12]
    next_drive.ccw_permit     = ccw_ok && (state == SDI_ON);
    next_drive.cw_permit      = cw_ok && (state == SDI_ON);
    next_drive.program_mode   = auto_sel;
    next_drive.trouble_output = alarm_any;
    events                = '0;
    events[IRQ_FSTOP]     = rising(!fstop_on, fstop_was);
    events[IRQ_ALARM]     = |(alarm_raise & ~alarm);
    events[IRQ_ALARM_CLR] = alarm_any && !(|next_alarm);
    events[IRQ_STROKE]    = rising(stroke_hit, stroke_was);
    events[IRQ_RESUME]    = next_resume;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state        <= SDI_OFF;
      drive        <= '0;
      fstop_was    <= 1'b0;
      stroke_was   <= 1'b0;
    end else begin
      state        <= next_state;
      drive        <= next_drive;
      fstop_was    <= !fstop_on;
      stroke_was   <= stroke_hit;
    end
  end

  // ****************************************************************
  // program resume
  // ****************************************************************
  // only a fresh press counts, so a held input cannot release two steps
  always_comb begin
    next_resume = sync1_wait
                  && rising(pins.program_resume_input_1, resume_was); // [RULE15]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_resume <= 1'b0;
      resume_was   <= 1'b0;
    end else begin
      sync1_resume <= next_resume;
      resume_was   <= pins.program_resume_input_1;
    end
  end

  // ****************************************************************
  // bidirectional pin
  // ****************************************************************
  // released unless it carries the trouble signal, so an input is never fought
  always_comb begin
    next_io_oen = (io_func != IO_TROUBLE_OUT); // [RULE13]
    next_io_out = (io_func == IO_TROUBLE_OUT) && alarm_any;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_pin_out <= 1'b0;
      io_pin_oen <= 1'b1;
    end else begin
      io_pin_out <= next_io_out;
      io_pin_oen <= next_io_oen;
    end
  end

  // ****************************************************************
  // status word
  // ****************************************************************
  always_comb begin
    status_word                                 = 32'h00000000;
    status_word[3:0]                            = state;
    status_word[ST_BASE]                        = drive.base_enable;
    status_word[ST_DBRAKE]                      = drive.dyn_brake;
    status_word[ST_CCW]                         = drive.ccw_permit;
    status_word[ST_CW]                          = drive.cw_permit;
    status_word[ST_FSTOP_IN]                    = fstop_on;
    status_word[ST_AUTO_IN]                     = auto_sel;
    status_word[ST_ALARM_LSB +: ALARM_W]        = alarm;
  end

endmodule

// ===== test/sdi_core_sva.sv
// port assertions of the servo discrete-input block
`timescale 1ns/1ps
module sdi_core_sva
  import sdi_pkg::*;
#(
  parameter logic [HOLD_W-1:0] RESET_HOLD = HOLD_W'(RESET_HOLD_CYC)
) (
  input logic       hclk,
  input logic       hresetn,
  input sdi_pins_t  pins,
  input logic       motion_ccw_req,
  input logic       motion_cw_req,
  input logic       sync1_wait,
  input logic       sync1_resume,
  input sdi_drive_t drive
);
  // ****************
  // helper logic
  // ****************
  logic [HOLD_W:0] run;
  logic [HOLD_W:0] last;
  logic            hit;
  // the last run is kept: the clear may land just after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run  <= '0;
      last <= '0;
    end else if (pins.alarm_reset_input) begin
      run <= run + 1'b1;
    end else begin
      run <= '0;
      if (run != '0) last <= run;
    end
  end
  assign hit = motion_ccw_req && !pins.fwd_stroke_end_input
            || motion_cw_req && !pins.rev_stroke_end_input;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // assertions
  // ****************
  brake_base_a: assert property (drive.dyn_brake |-> !drive.base_enable)
    else $error("dynamic brake with base on");
  base_cause_a: assert property ($rose(drive.base_enable) |-> $past(pins.servo_on_input, 2))
    else $error("base on without servo-on");
  base_coast_a: assert property (!pins.servo_on_input [*2] |=> !drive.base_enable)
    else $error("base on after servo-on off");
  reset_hold_a: assert property ($fell(drive.trouble_output) |->
      (run > {1'b0, RESET_HOLD} || last > {1'b0, RESET_HOLD}))
    else $error("alarm cleared by short reset");
  stop_cause_a: assert property ((drive.sudden_stop || drive.slow_stop) |-> $past(hit))
    else $error("stop without stroke end");
  stop_lock_a: assert property (drive.sudden_stop |-> drive.servo_lock)
    else $error("sudden stop without lock");
  stop_kind_a: assert property (!(drive.sudden_stop && drive.slow_stop))
    else $error("both stop kinds at once");
  ccw_gate_a: assert property (!pins.fwd_stroke_end_input [*2] |=> !drive.ccw_permit)
    else $error("ccw permitted at stroke end");
  cw_gate_a: assert property (!pins.rev_stroke_end_input [*2] |=> !drive.cw_permit)
    else $error("cw permitted at stroke end");
  resume_go_a: assert property ($rose(pins.program_resume_input_1) && sync1_wait
      |=> sync1_resume)
    else $error("resume pulse missing");
  resume_why_a: assert property (sync1_resume |-> $past(sync1_wait))
    else $error("resume without wait");
  cover property (drive.slow_stop);
  cover property (drive.sudden_stop);
  cover property (sync1_resume);
  cover property ($fell(drive.trouble_output));
endmodule

bind sdi_core sdi_core_sva #(.RESET_HOLD(RESET_HOLD)) sva_i (
  .hclk(hclk), .hresetn(hresetn), .pins(pins), .motion_ccw_req(motion_ccw_req),
  .motion_cw_req(motion_cw_req), .sync1_wait(sync1_wait), .sync1_resume(sync1_resume),
  .drive(drive)
);

// ===== test/sdi_plc_model.sv
// behavioural controller that drives the discrete inputs
`timescale 1ns/1ps
module sdi_plc_model
  import sdi_pkg::*;
(
  input  logic      hclk,
  output sdi_pins_t pins,
  output logic      io_pin_in
);
  // ****************
  // contact inputs
  // ****************
  initial begin
    pins      = 5'h06;
    io_pin_in = 1'b1;
  end
  task automatic put(input int i, input logic v);
    @(posedge hclk);
    pins[i] <= v;
  endtask
  task automatic io(input logic v);
    @(posedge hclk);
    io_pin_in <= v;
  endtask
  // only pressed while no motion is commanded
  task automatic hold(input int n);
    @(posedge hclk);
    pins.alarm_reset_input <= 1'b1;
    repeat (n) @(posedge hclk);
    pins.alarm_reset_input <= 1'b0;
  endtask
endmodule

// ===== test/test_servo_discrete_input_control.sv
// self-checking bench of the servo discrete-input block
`timescale 1ns/1ps
module test_servo_discrete_input_control
  import sdi_pkg::*;
;
  // ****************
  // harness
  // ****************
  localparam logic [HOLD_W-1:0] RH = HOLD_W'(20);
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  alarm_raise;
  logic        hclk = 1'b0;
  logic        hresetn, hwrite, hreadyout, hresp, irq, plc_io;
  logic        motion_ccw_req, motion_cw_req, sync1_wait, sync1_resume;
  logic        io_pin_out, io_pin_oen;
  wire logic   io_wire;
  sdi_pins_t   pins;
  sdi_drive_t  drive;
  int          n_mismatch, checks_done, c;

  assign io_wire = io_pin_oen ? plc_io : io_pin_out;
  always #12.5 hclk = ~hclk;

  sdi_core #(.RESET_HOLD(RH)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .io_pin_in(io_wire),
    .io_pin_out(io_pin_out), .io_pin_oen(io_pin_oen), .alarm_raise(alarm_raise),
    .motion_ccw_req(motion_ccw_req), .motion_cw_req(motion_cw_req),
    .sync1_wait(sync1_wait), .sync1_resume(sync1_resume), .drive(drive), .irq(irq));
  sdi_plc_model plc (.hclk(hclk), .pins(pins), .io_pin_in(plc_io));

  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic rdy;
    for (int n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_mismatch++;
    wrap_up();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic raise(input logic [7:0] a);
    @(posedge hclk);
    alarm_raise <= a;
    @(posedge hclk);
    alarm_raise <= 8'h00;
    tk(2);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic s_init;
    tk(2);
    chk(drive.program_mode, 1'b1);
    rchk(ADDR_STATUS, 32'h30f, 32'h301);
    rchk(ADDR_CTRL, 32'hf, 32'h0);
    rchk(8'h14, 32'hffffffff, 32'h0);
    chk(hresp, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h8);
    plc.io(1'b0);
    tk(2);
    chk(drive.program_mode, 1'b0);
    rchk(ADDR_STATUS, 32'h300, 32'h100);
    plc.io(1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0);
  endtask
  task automatic s_fstop;
    bus(1'b1, ADDR_CTRL, 32'h4);
    plc.put(4, 1'b1);
    tk(3);
    plc.io(1'b0);
    tk(3);
    rchk(ADDR_STATUS, 32'h3f, 32'h24);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_INT_ENABLE, 32'h1f);
    tk(1);
    chk(irq, 1'b1);
    bus(1'b1, ADDR_INT_CLEAR, 32'h1f);
    tk(1);
    chk(irq, 1'b0);
    plc.put(4, 1'b0);
    plc.io(1'b1);
    tk(3);
    rchk(ADDR_STATUS, 32'h13f, 32'h101);
    bus(1'b1, ADDR_CTRL, 32'hc);
    tk(2);
    chk({io_pin_oen, io_wire}, 2'h0);
    bus(1'b1, ADDR_CTRL, 32'h0);
  endtask
  task automatic s_servo;
    plc.put(4, 1'b1);
    tk(3);
    rchk(ADDR_STATUS, 32'h1f, 32'h12);
    plc.put(3, 1'b1);
    tk(3);
    chk(drive.base_enable, 1'b0);
    plc.put(3, 1'b0);
    tk(3);
    chk(drive.base_enable, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h2);
    plc.put(3, 1'b1);
    tk(3);
    chk(drive.base_enable, 1'b1);
    plc.put(3, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0);
  endtask
  task automatic s_stroke;
    @(posedge hclk);
    motion_ccw_req <= 1'b1;
    plc.put(2, 1'b0);
    tk(3);
    chk(drive[6:2], 5'h19);
    rchk(ADDR_INT_STATUS, 32'h8, 32'h8);
    bus(1'b1, ADDR_CTRL, 32'h1);
    tk(2);
    chk({drive.sudden_stop, drive.slow_stop}, 2'h1);
    @(posedge hclk);
    motion_ccw_req <= 1'b0;
    motion_cw_req  <= 1'b1;
    plc.put(1, 1'b0);
    tk(3);
    chk({drive.slow_stop, drive.ccw_permit, drive.cw_permit}, 3'h4);
    plc.put(2, 1'b1);
    plc.put(1, 1'b1);
    motion_cw_req <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h0);
    tk(3);
    chk(drive[5:2], 4'h3);
    plc.put(4, 1'b0);
    tk(3);
    chk({drive.base_enable, drive.dyn_brake}, 2'h0);
    rchk(ADDR_STATUS, 32'hf, 32'h1);
  endtask
  task automatic s_resume;
    @(posedge hclk);
    sync1_wait <= 1'b1;
    plc.put(0, 1'b1);
    c = 0;
    repeat (4) begin
      tk(1);
      if (sync1_resume === 1'b1) c++;
    end
    chk(c, 1);
    plc.put(0, 1'b0);
    sync1_wait <= 1'b0;
    plc.put(0, 1'b1);
    c = 0;
    repeat (4) begin
      tk(1);
      if (sync1_resume !== 1'b0) c++;
    end
    chk(c, 0);
    plc.put(0, 1'b0);
  endtask
  task automatic s_alarm;
    raise(8'h01);
    chk(drive.trouble_output, 1'b1);
    plc.hold(RH);
    tk(3);
    rchk(ADDR_STATUS, 32'hff000f, 32'h010008);
    plc.hold(RH + 1);
    tk(3);
    rchk(ADDR_STATUS, 32'hff0000, 32'h0);
    rchk(ADDR_INT_STATUS, 32'h6, 32'h6);
    raise(8'h80);
    plc.hold(RH + 1);
    tk(3);
    rchk(ADDR_STATUS, 32'hff0000, 32'h800000);
    chk(drive.trouble_output, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'hc);
    tk(2);
    chk({io_pin_oen, io_wire}, 2'h1);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    hresetn = 1'b0;
    {htrans, haddr, hwrite, hwdata, alarm_raise} = '0;
    {motion_ccw_req, motion_cw_req, sync1_wait} = 3'h0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    s_init();
    s_fstop();
    s_servo();
    s_stroke();
    s_resume();
    s_alarm();
    wrap_up();
  end
  // a hang is cut short well inside the cycle budget
  initial begin
    #2_000_000;
    n_mismatch++;
    wrap_up();
  end
endmodule
